/* pkg/aic_pkg.sv */
package aic_pkg;

  // Clock and power-down timer base
  localparam int CLK_PERIOD_NS = 100;
  localparam int APD_STEP_NS   = 5_000_000;
  localparam int APD_STEP_CYC  = APD_STEP_NS / CLK_PERIOD_NS;
  localparam int TICK_W        = 16;

  // Task file register selects
  localparam logic [2:0] TF_COUNT   = 3'h2;
  localparam logic [2:0] TF_LBA_LO  = 3'h3;
  localparam logic [2:0] TF_LBA_MID = 3'h4;
  localparam logic [2:0] TF_LBA_HI  = 3'h5;
  localparam logic [2:0] TF_DEVHEAD = 3'h6;
  localparam logic [2:0] TF_CMD     = 3'h7;

  // Command codes
  localparam logic [7:0] CMD_IDLE_A   = 8'h97;
  localparam logic [7:0] CMD_IDLE_B   = 8'he3;
  localparam logic [7:0] CMD_IDLI_A   = 8'h95;
  localparam logic [7:0] CMD_IDLI_B   = 8'he1;
  localparam logic [7:0] CMD_LOCK     = 8'hde;
  localparam logic [7:0] CMD_UNLOCK   = 8'hdf;
  localparam logic [7:0] CMD_NOP      = 8'h00;
  localparam logic [7:0] CMD_RDBUF    = 8'he4;
  localparam logic [7:0] CMD_RDDMA    = 8'hc8;
  localparam logic [7:0] CMD_RDDMA_X  = 8'h25;

  // Sector geometry and counts
  localparam int          WORDS       = 256;
  localparam logic [7:0]  LAST_WORD   = 8'hff;
  localparam logic [16:0] SEC28_MAX   = 17'h0_0100;
  localparam logic [16:0] SEC48_MAX   = 17'h1_0000;
  localparam logic [16:0] SEC_ONE     = 17'h0_0001;
  localparam logic [27:0] LBA28_ONE   = 28'h000_0001;
  localparam logic [47:0] LBA48_ONE   = 48'h0000_0000_0001;

  // Write protect status word bit positions
  localparam int WP_SPARE_BIT = 15;
  localparam int WP_TABLE_BIT = 14;
  localparam int RP_TABLE_BIT = 13;
  localparam int WP_VPERM_BIT = 9;
  localparam int WP_VTEMP_BIT = 8;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_EXEC = 5'h02,
    ST_FILL = 5'h04,
    ST_XFER = 5'h08,
    ST_PIO  = 5'h10
  } aic_state_t;

  typedef struct packed {
    aic_state_t  st;
    logic [7:0]  cmd;
    logic [7:0]  devhead;
    logic [47:0] lba;
    logic [16:0] remain;
    logic        ext;
    logic [7:0]  widx;
    logic        bsy;
    logic        drq;
    logic        dmarq;
    logic        fetch;
    logic        err;
    logic        abrt;
    logic        intrq;
    logic        idle;
    logic        apd_en;
    logic        apd_req;
    logic [7:0]  apd_cnt;
    logic [15:0] dd;
    logic [15:0] wp;
  } aic_core_t;

  typedef struct packed {
    logic [7:0] cur;
    logic [7:0] prev;
  } aic_tfreg_t;

  typedef struct packed {
    logic [TICK_W-1:0] cnt;
    logic              tick;
  } aic_tick_t;

endpackage

/* src/aic_tfreg.sv */
`timescale 1ns/1ps
`default_nettype none
module aic_tfreg (
  // Clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_resetn,
  // Write side
  input  wire logic       i_we,
  input  wire logic [7:0] i_data,
  // Current and previous written byte
  output logic [7:0]      o_cur,
  output logic [7:0]      o_prev
);
  aic_pkg::aic_tfreg_t r_reg;
  aic_pkg::aic_tfreg_t r_next;

  // Each write pushes the older byte into the previous slot
  always_comb begin
    r_next = r_reg;
    if (i_we) begin
      r_next.prev = r_reg.cur;
      r_next.cur  = i_data;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign o_cur  = r_reg.cur;
  assign o_prev = r_reg.prev;
endmodule
`default_nettype wire

/* src/aic_tick.sv */
`timescale 1ns/1ps
`default_nettype none
module aic_tick #(
  parameter int P_CYC = aic_pkg::APD_STEP_CYC
) (
  // Clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_resetn,
  // Control
  input  wire logic i_run,
  input  wire logic i_clr,
  // One-cycle enable per step
  output logic      o_tick
);
  aic_pkg::aic_tick_t r_reg;
  aic_pkg::aic_tick_t r_next;
  localparam logic [aic_pkg::TICK_W-1:0] LAST =
    aic_pkg::TICK_W'(P_CYC - 1);
  localparam logic [aic_pkg::TICK_W-1:0] ONE =
    aic_pkg::TICK_W'(1);

  // Divider restarts on clear so a fresh timer gets a full first step
  always_comb begin
    r_next      = r_reg;
    r_next.tick = 1'b0;
    if (i_clr || !i_run) begin
      r_next.cnt = '0;
    end else if (r_reg.cnt == LAST) begin
      r_next.cnt  = '0;
      r_next.tick = 1'b1;
    end else begin
      r_next.cnt = r_reg.cnt + ONE;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign o_tick = r_reg.tick;
endmodule
`default_nettype wire

/* src/aic_top.sv */
// Overview of operation
// - Status word bits 15,14,13: protect conditions
// - Bits 9 and 8: vendor write protects
// - Idle: busy, enter idle, interrupt
// - Nonzero count loads power-down timer in 5 ms steps
// - Zero count disables automatic power-down
// - Idle immediate: idle, interrupt, no timer
// - Media lock/unlock always abort
// - NOP always aborts
// - Read buffer returns buffer by PIO
// - Read DMA: count 0 means 256
// - Busy while filling the first sector, then DRQ, busy off
// - DMA request while buffered data available
// - Interrupt only at end or on error
// - Registers hold last or failing sector
// - Read DMA ext: count 0 means 65536
// - Two writes form 48-bit address
// - Ext read leaves 48-bit last address
// - Ext read aborts in 8-bit mode
`timescale 1ns/1ps
`default_nettype none
module aic_top #(
  parameter int P_STEP_CYC = aic_pkg::APD_STEP_CYC
) (
  // Clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_resetn,
  // Task file writes and status read
  input  wire logic        i_tf_wr,
  input  wire logic [2:0]  i_tf_sel,
  input  wire logic [7:0]  i_tf_data,
  input  wire logic        i_stat_rd,
  input  wire logic        i_feat_8bit,
  // Data transfer from host side
  input  wire logic        i_dmack,
  input  wire logic        i_iord,
  input  wire logic        i_pio_rd,
  // Media fill side
  input  wire logic        i_fill_valid,
  input  wire logic [15:0] i_fill_data,
  input  wire logic        i_fill_err,
  // Protect condition levels
  input  wire logic        i_wp_spare,
  input  wire logic        i_wp_table,
  input  wire logic        i_rp_table,
  input  wire logic        i_wp_vperm,
  input  wire logic        i_wp_vtemp,
  // Status
  output logic             o_bsy,
  output logic             o_drq,
  output logic             o_err,
  output logic             o_abrt,
  output logic             o_intrq,
  output logic             o_idle,
  output logic             o_apd_en,
  output logic             o_apd_req,
  output logic [15:0]      o_wp_status,
  // Data and address
  output logic             o_dmarq,
  output logic [15:0]      o_dd,
  output logic             o_fetch,
  output logic [47:0]      o_lba
);
  aic_pkg::aic_core_t r_reg;
  aic_pkg::aic_core_t r_next;
  logic [15:0] sbuf [aic_pkg::WORDS];
  logic [7:0]  cnt_cur;
  logic [7:0]  cnt_prev;
  logic [7:0]  lo_cur;
  logic [7:0]  lo_prev;
  logic [7:0]  mid_cur;
  logic [7:0]  mid_prev;
  logic [7:0]  hi_cur;
  logic [7:0]  hi_prev;
  logic        tick;
  logic        cmd_wr;

  // Command writes while busy are dropped, as the host may not issue them
  assign cmd_wr = i_tf_wr && (i_tf_sel == aic_pkg::TF_CMD) && !r_reg.bsy;

  // Address and count registers keep the previous write for 48-bit use
  aic_tfreg u_cnt (
    .i_ref_clk (i_ref_clk),
    .i_resetn  (i_resetn),
    .i_we      (i_tf_wr && i_tf_sel == aic_pkg::TF_COUNT),
    .i_data    (i_tf_data),
    .o_cur     (cnt_cur),
    .o_prev    (cnt_prev)
  );
  aic_tfreg u_lo (
    .i_ref_clk (i_ref_clk),
    .i_resetn  (i_resetn),
    .i_we      (i_tf_wr && i_tf_sel == aic_pkg::TF_LBA_LO),
    .i_data    (i_tf_data),
    .o_cur     (lo_cur),
    .o_prev    (lo_prev)
  );
  aic_tfreg u_mid (
    .i_ref_clk (i_ref_clk),
    .i_resetn  (i_resetn),
    .i_we      (i_tf_wr && i_tf_sel == aic_pkg::TF_LBA_MID),
    .i_data    (i_tf_data),
    .o_cur     (mid_cur),
    .o_prev    (mid_prev)
  );
  aic_tfreg u_hi (
    .i_ref_clk (i_ref_clk),
    .i_resetn  (i_resetn),
    .i_we      (i_tf_wr && i_tf_sel == aic_pkg::TF_LBA_HI),
    .i_data    (i_tf_data),
    .o_cur     (hi_cur),
    .o_prev    (hi_prev)
  );

  // Power-down step divider, runs only while the timer is armed
  aic_tick #(
    .P_CYC (P_STEP_CYC)
  ) u_tick (
    .i_ref_clk (i_ref_clk),
    .i_resetn  (i_resetn),
    .i_run     (r_reg.idle && r_reg.apd_en),
    .i_clr     (r_reg.st == aic_pkg::ST_EXEC),
    .o_tick    (tick)
  );

  // Sector buffer fill; no reset, contents are whatever was last read
  always_ff @(posedge i_ref_clk) begin
    if (r_reg.st == aic_pkg::ST_FILL && i_fill_valid && !i_fill_err) begin
      sbuf[r_reg.widx] <= i_fill_data;
    end
  end

  // Command sequencer; status clear comes first so a set in the same
  // cycle wins over the host reading status
  always_comb begin
    r_next = r_reg;
    r_next.wp = '0;
    r_next.wp[aic_pkg::WP_SPARE_BIT] = i_wp_spare;
    r_next.wp[aic_pkg::WP_TABLE_BIT] = i_wp_table;
    r_next.wp[aic_pkg::RP_TABLE_BIT] = i_rp_table;
    r_next.wp[aic_pkg::WP_VPERM_BIT] = i_wp_vperm;
    r_next.wp[aic_pkg::WP_VTEMP_BIT] = i_wp_vtemp;
    if (i_stat_rd) begin
      r_next.intrq = 1'b0;
    end
    if (i_tf_wr && i_tf_sel == aic_pkg::TF_DEVHEAD) begin
      r_next.devhead = i_tf_data;
    end
    if (r_reg.idle && r_reg.apd_en && tick && r_reg.apd_cnt != 8'h00) begin
      r_next.apd_cnt = r_reg.apd_cnt - 8'h01;
      if (r_reg.apd_cnt == 8'h01) begin
        r_next.apd_req = 1'b1;
      end
    end
    unique case (r_reg.st)
      aic_pkg::ST_IDLE: begin
        if (cmd_wr) begin
          r_next.st      = aic_pkg::ST_EXEC;
          r_next.cmd     = i_tf_data;
          r_next.bsy     = 1'b1;
          r_next.err     = 1'b0;
          r_next.abrt    = 1'b0;
          r_next.intrq   = 1'b0;
          r_next.drq     = 1'b0;
          r_next.apd_req = 1'b0;
          r_next.widx    = 8'h00;
        end
      end
      aic_pkg::ST_EXEC: begin
        r_next.bsy = 1'b0;
        r_next.st  = aic_pkg::ST_IDLE;
        case (r_reg.cmd)
          aic_pkg::CMD_IDLE_A, aic_pkg::CMD_IDLE_B: begin
            r_next.idle    = 1'b1;
            r_next.intrq   = 1'b1;
            r_next.apd_en  = (cnt_cur != 8'h00);
            r_next.apd_cnt = cnt_cur;
          end
          aic_pkg::CMD_IDLI_A, aic_pkg::CMD_IDLI_B: begin
            r_next.idle  = 1'b1;
            r_next.intrq = 1'b1;
          end
          aic_pkg::CMD_RDBUF: begin
            r_next.st    = aic_pkg::ST_PIO;
            r_next.drq   = 1'b1;
            r_next.intrq = 1'b1;
          end
          aic_pkg::CMD_RDDMA: begin
            r_next.bsy   = 1'b1;
            r_next.st    = aic_pkg::ST_FILL;
            r_next.fetch = 1'b1;
            r_next.ext   = 1'b0;
            r_next.lba   = {20'h0_0000, r_reg.devhead[3:0],
                            hi_cur, mid_cur, lo_cur};
            r_next.remain = (cnt_cur == 8'h00) ? aic_pkg::SEC28_MAX
                                               : {9'h000, cnt_cur};
          end
          aic_pkg::CMD_RDDMA_X: begin
            if (i_feat_8bit) begin
              r_next.err   = 1'b1;
              r_next.abrt  = 1'b1;
              r_next.intrq = 1'b1;
            end else begin
              r_next.bsy   = 1'b1;
              r_next.st    = aic_pkg::ST_FILL;
              r_next.fetch = 1'b1;
              r_next.ext   = 1'b1;
              r_next.lba   = {hi_prev, mid_prev, lo_prev,
                              hi_cur, mid_cur, lo_cur};
              r_next.remain = ({cnt_prev, cnt_cur} == 16'h0000)
                ? aic_pkg::SEC48_MAX
                : {1'b0, cnt_prev, cnt_cur};
            end
          end
          aic_pkg::CMD_LOCK, aic_pkg::CMD_UNLOCK, aic_pkg::CMD_NOP: begin
            r_next.err   = 1'b1;
            r_next.abrt  = 1'b1;
            r_next.intrq = 1'b1;
          end
          default: begin
            r_next.err   = 1'b1;
            r_next.abrt  = 1'b1;
            r_next.intrq = 1'b1;
          end
        endcase
      end
      aic_pkg::ST_FILL: begin
        if (i_fill_err) begin
          // Stop at the failing sector; lba still names it
          r_next.st    = aic_pkg::ST_IDLE;
          r_next.err   = 1'b1;
          r_next.intrq = 1'b1;
          r_next.bsy   = 1'b0;
          r_next.drq   = 1'b0;
          r_next.fetch = 1'b0;
        end else if (i_fill_valid) begin
          r_next.widx = r_reg.widx + 8'h01;
          if (r_reg.widx == aic_pkg::LAST_WORD) begin
            r_next.st    = aic_pkg::ST_XFER;
            r_next.fetch = 1'b0;
            r_next.dmarq = 1'b1;
            r_next.bsy   = 1'b0;
            r_next.drq   = 1'b1;
          end
        end
      end
      aic_pkg::ST_XFER: begin
        if (i_dmack && i_iord) begin
          r_next.widx = r_reg.widx + 8'h01;
          if (r_reg.widx == aic_pkg::LAST_WORD) begin
            r_next.dmarq = 1'b0;
            if (r_reg.remain == aic_pkg::SEC_ONE) begin
              r_next.st    = aic_pkg::ST_IDLE;
              r_next.drq   = 1'b0;
              r_next.intrq = 1'b1;
            end else begin
              r_next.remain = r_reg.remain - aic_pkg::SEC_ONE;
              r_next.st     = aic_pkg::ST_FILL;
              r_next.fetch  = 1'b1;
              // Advance only when another sector follows
              r_next.lba = r_reg.ext ? r_reg.lba + aic_pkg::LBA48_ONE
                : {20'h0_0000, r_reg.lba[27:0] + aic_pkg::LBA28_ONE};
            end
          end
        end
      end
      aic_pkg::ST_PIO: begin
        if (i_pio_rd) begin
          r_next.widx = r_reg.widx + 8'h01;
          if (r_reg.widx == aic_pkg::LAST_WORD) begin
            r_next.st  = aic_pkg::ST_IDLE;
            r_next.drq = 1'b0;
          end
        end
      end
    endcase
    // Present the word that the next strobe will take
    r_next.dd = sbuf[r_next.widx];
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      r_reg    <= '0;
      r_reg.st <= aic_pkg::ST_IDLE;
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs come straight from the state register
  assign o_bsy       = r_reg.bsy;
  assign o_drq       = r_reg.drq;
  assign o_err       = r_reg.err;
  assign o_abrt      = r_reg.abrt;
  assign o_intrq     = r_reg.intrq;
  assign o_idle      = r_reg.idle;
  assign o_apd_en    = r_reg.apd_en;
  assign o_apd_req   = r_reg.apd_req;
  assign o_wp_status = r_reg.wp;
  assign o_dmarq     = r_reg.dmarq;
  assign o_dd        = r_reg.dd;
  assign o_fetch     = r_reg.fetch;
  assign o_lba       = r_reg.lba;

  // Checks on command outcomes
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);

  logic cmd_go;
  assign cmd_go = cmd_wr && r_reg.st == aic_pkg::ST_IDLE && !i_stat_rd;

  AST_WP_HIGH: assert property (##1 o_wp_status[15:13] ==
    $past({i_wp_spare, i_wp_table, i_rp_table}))
    else $error("protect bits 15..13 wrong");
  AST_WP_VEND: assert property (##1 o_wp_status[9:8] ==
    $past({i_wp_vperm, i_wp_vtemp}))
    else $error("vendor protect bits wrong");
  AST_IDLE_DONE: assert property (cmd_go &&
    (i_tf_data == aic_pkg::CMD_IDLE_A || i_tf_data == aic_pkg::CMD_IDLE_B)
    |=> o_bsy ##1 (!o_bsy && o_idle && o_intrq && !o_err))
    else $error("idle did not complete");
  AST_APD_ON: assert property (cmd_go && cnt_cur != 8'h00 &&
    i_tf_data == aic_pkg::CMD_IDLE_A
    |-> ##2 (o_apd_en && r_reg.apd_cnt == $past(cnt_cur, 2)))
    else $error("timer not armed");
  AST_APD_OFF: assert property (cmd_go && cnt_cur == 8'h00 &&
    i_tf_data == aic_pkg::CMD_IDLE_B |-> ##2 !o_apd_en)
    else $error("timer not disabled");
  AST_IDLI: assert property (cmd_go && i_tf_data == aic_pkg::CMD_IDLI_A
    |-> ##2 (o_idle && o_intrq && o_apd_en == $past(o_apd_en, 2)))
    else $error("idle immediate wrong");
  AST_ABORT: assert property (cmd_go &&
    (i_tf_data == aic_pkg::CMD_NOP || i_tf_data == aic_pkg::CMD_LOCK ||
     i_tf_data == aic_pkg::CMD_UNLOCK)
    |-> ##2 (o_err && o_abrt && o_intrq && !o_bsy))
    else $error("abort not reported");
  AST_EXT_8BIT: assert property (cmd_go && i_feat_8bit &&
    i_tf_data == aic_pkg::CMD_RDDMA_X |-> ##2 (o_abrt && !o_dmarq))
    else $error("ext read not aborted");
  AST_NO_MID_INT: assert property (r_reg.st == aic_pkg::ST_XFER &&
    !(i_dmack && i_iord) |=> !$rose(o_intrq))
    else $error("interrupt during transfer");
  AST_FILL_BSY: assert property ($rose(o_fetch) && o_bsy
    |-> o_bsy throughout (r_reg.st == aic_pkg::ST_FILL)[*2])
    else $error("busy dropped during first fill");
  AST_LBA_STEP: assert property (r_reg.st == aic_pkg::ST_XFER &&
    i_dmack && i_iord && r_reg.widx == aic_pkg::LAST_WORD &&
    r_reg.remain != aic_pkg::SEC_ONE && r_reg.ext
    |=> o_lba == $past(o_lba) + aic_pkg::LBA48_ONE)
    else $error("address did not advance");
  AST_CNT28: assert property (cmd_go && i_tf_data == aic_pkg::CMD_RDDMA
    && cnt_cur == 8'h00 |-> ##2 r_reg.remain == aic_pkg::SEC28_MAX)
    else $error("count zero not 256");
  AST_DMARQ: assert property (o_dmarq |->
    r_reg.st == aic_pkg::ST_XFER)
    else $error("dma request without data");

  COV_IDLE: cover property (cmd_go && i_tf_data == aic_pkg::CMD_IDLE_A);
  COV_DMA_END: cover property (r_reg.st == aic_pkg::ST_XFER ##1
    r_reg.st == aic_pkg::ST_IDLE && o_intrq);
  COV_FILL_ERR: cover property (r_reg.st == aic_pkg::ST_FILL && i_fill_err);
  COV_APD: cover property ($rose(o_apd_req));
endmodule
`default_nettype wire

/* testbench/aic_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Host DMA reader; slow mode strobes every other cycle
module aic_host_model (
  // Clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_resetn,
  // Bench control
  input  wire logic        i_slow,
  input  wire logic        i_clr,
  // Device side
  input  wire logic        i_dmarq,
  input  wire logic [15:0] i_dd,
  output logic             o_dmack,
  output logic             o_iord,
  // Words taken and their sum
  output logic [31:0]      o_words,
  output logic [15:0]      o_sum
);
  logic [7:0] wcnt_reg;
  logic       take;
  logic       more;
  // A word moves on an edge with strobe, ack and request high
  assign take = o_iord && o_dmack && i_dmarq;
  // Stop after word 256, since the request drops one cycle late
  assign more = i_dmarq && !(take && wcnt_reg == 8'hff);
  // Ack while requested, one strobe per 16-bit word
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wcnt_reg <= 8'h00;
      o_dmack  <= 1'b0;
      o_iord   <= 1'b0;
      o_words  <= 32'h0000_0000;
      o_sum    <= 16'h0000;
    end else begin
      if (take) begin
        wcnt_reg <= wcnt_reg + 8'h01;
      end
      o_dmack <= more;
      o_iord  <= more && !(i_slow && o_iord);
      if (i_clr) begin
        o_words <= 32'h0000_0000;
        o_sum   <= 16'h0000;
      end else if (take) begin
        o_words <= o_words + 32'h0000_0001;
        o_sum   <= o_sum + i_dd;
      end
    end
  end
endmodule
`default_nettype wire

/* testbench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct packed {
    logic [7:0]  cmd;
    logic [7:0]  cnt;
    logic        f8;
    logic [4:0]  wp;
    logic        chk_apd;
    logic [2:0]  res;
    logic [15:0] wp_exp;
  } aic_row_t;
  logic        clk;
  logic        resetn;
  logic        tf_wr;
  logic [2:0]  tf_sel;
  logic [7:0]  tf_data;
  logic        stat_rd;
  logic        f8;
  logic        pio_rd;
  logic        fill_v;
  logic [15:0] fill_d;
  logic        fill_err;
  logic [4:0]  wp_in;
  logic        slow;
  logic        hclr;
  logic        dmack;
  logic        iord;
  logic [31:0] words;
  logic [15:0] hsum;
  logic [15:0] esum;
  logic [15:0] o_wp_status;
  logic [15:0] o_dd;
  logic [47:0] o_lba;
  logic        o_bsy, o_drq, o_err, o_abrt, o_intrq, o_idle;
  logic        o_apd_en, o_apd_req, o_dmarq, o_fetch;
  int          fail_count;
  int          comparisons;
  aic_row_t    r;
  // Rows: code, count, 8-bit mode, protect levels, err/abrt/apd
  aic_row_t rows [8] = '{
    '{8'h97, 8'h05, 1'b0, 5'h10, 1'b1, 3'h1, 16'h8000},
    '{8'he3, 8'h00, 1'b0, 5'h08, 1'b1, 3'h0, 16'h4000},
    '{8'h95, 8'h07, 1'b0, 5'h04, 1'b1, 3'h0, 16'h2000},
    '{8'he1, 8'h07, 1'b0, 5'h02, 1'b1, 3'h0, 16'h0200},
    '{8'hde, 8'h00, 1'b0, 5'h01, 1'b0, 3'h6, 16'h0100},
    '{8'hdf, 8'h00, 1'b0, 5'h1f, 1'b0, 3'h6, 16'he300},
    '{8'h00, 8'h00, 1'b0, 5'h00, 1'b0, 3'h6, 16'h0000},
    '{8'h25, 8'h00, 1'b1, 5'h00, 1'b0, 3'h6, 16'h0000}
  };

  aic_top #(.P_STEP_CYC(4)) u_dut (
    .i_ref_clk(clk), .i_resetn(resetn),
    .i_tf_wr(tf_wr), .i_tf_sel(tf_sel), .i_tf_data(tf_data),
    .i_stat_rd(stat_rd), .i_feat_8bit(f8),
    .i_dmack(dmack), .i_iord(iord), .i_pio_rd(pio_rd),
    .i_fill_valid(fill_v), .i_fill_data(fill_d),
    .i_fill_err(fill_err),
    .i_wp_spare(wp_in[4]), .i_wp_table(wp_in[3]),
    .i_rp_table(wp_in[2]), .i_wp_vperm(wp_in[1]),
    .i_wp_vtemp(wp_in[0]),
    .o_bsy(o_bsy), .o_drq(o_drq), .o_err(o_err), .o_abrt(o_abrt),
    .o_intrq(o_intrq), .o_idle(o_idle), .o_apd_en(o_apd_en),
    .o_apd_req(o_apd_req), .o_wp_status(o_wp_status),
    .o_dmarq(o_dmarq), .o_dd(o_dd), .o_fetch(o_fetch), .o_lba(o_lba)
  );

  aic_host_model u_host (
    .i_ref_clk(clk), .i_resetn(resetn), .i_slow(slow),
    .i_clr(hclr), .i_dmarq(o_dmarq), .i_dd(o_dd),
    .o_dmack(dmack), .o_iord(iord), .o_words(words), .o_sum(hsum)
  );

  // Free-running 10 MHz clock
  always #50 clk = ~clk;

  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tf(input logic [2:0] s, input logic [7:0] d);
    @(negedge clk);
    tf_wr = 1'b1;
    tf_sel = s;
    tf_data = d;
    @(negedge clk);
    tf_wr = 1'b0;
  endtask

  task automatic wr4(input logic [7:0] c, lo, mid, hi);
    tf(3'h2, c);
    tf(3'h3, lo);
    tf(3'h4, mid);
    tf(3'h5, hi);
  endtask

  // Command write: busy stands in the cycle after it, result one later
  task automatic issue(input logic [7:0] c);
    tf(3'h7, c);
    chk(o_bsy, 1'b1);
    @(negedge clk);
  endtask

  task automatic stat();
    @(negedge clk);
    stat_rd = 1'b1;
    @(negedge clk);
    stat_rd = 1'b0;
  endtask

  task automatic pio();
    @(negedge clk);
    pio_rd = 1'b1;
    @(negedge clk);
    pio_rd = 1'b0;
  endtask

  // New host pass: clear its tally and the expected sum
  task automatic start(input logic s);
    @(negedge clk);
    slow = s;
    hclr = 1'b1;
    esum = 16'h0000;
    @(negedge clk);
    hclr = 1'b0;
  endtask

  // Media side: a full sector, or a few words then a fault
  task automatic fill(input int s, input bit bad);
    int n;
    for (n = 0; n < 1200 && o_fetch !== 1'b1; n++) @(negedge clk);
    chk(o_intrq, 1'b0);
    chk(o_dmarq, 1'b0);
    for (n = 0; n < (bad ? 9 : 256); n++) begin
      @(negedge clk);
      fill_v = 1'b1;
      fill_d = {s[7:0], n[7:0]};
      if (!bad) esum = esum + fill_d;
    end
    @(negedge clk);
    fill_v = 1'b0;
    fill_err = bad;
    @(negedge clk);
    fill_err = 1'b0;
    if (!bad) chk(o_dmarq, 1'b1);
    if (!bad && s == 0) chk({o_bsy, o_drq}, 2'h1);
  endtask

  // Whole DMA read; the fault lands in sector bad_s
  task automatic run(input int ns, input int bad_s);
    int s;
    for (s = 0; s < ns; s++) fill(s, s == bad_s);
    for (s = 0; s < 1200 && o_intrq !== 1'b1; s++) @(negedge clk);
    chk({o_intrq, o_bsy}, 2'h2);
  endtask

  task automatic give_verdict();
    if (fail_count == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run length
  initial begin
    #3_000_000;
    fail_count++;
    give_verdict();
  end

  // Main sequence: reset, command rows, timer, DMA and buffer cases
  initial begin
    int n;
    clk = 1'b0;
    resetn = 1'b0;
    {tf_wr, stat_rd, f8, pio_rd, fill_v, fill_err, slow, hclr} = 8'h00;
    tf_sel = 3'h0;
    tf_data = 8'h00;
    fill_d = 16'h0000;
    wp_in = 5'h00;
    esum = 16'h0000;
    // Look only after clock edges in reset, so no time-zero race matters
    repeat (2) @(negedge clk);
    chk({o_bsy, o_intrq, o_dmarq, o_fetch, o_err}, 5'h00);
    resetn = 1'b1;
    foreach (rows[k]) begin
      r = rows[k];
      wp_in = r.wp;
      f8 = r.f8;
      tf(3'h2, r.cnt);
      issue(r.cmd);
      chk({o_bsy, o_intrq}, 2'h1);
      chk({o_err, o_abrt}, r.res[2:1]);
      if (!r.res[1]) chk(o_idle, 1'b1);
      if (r.chk_apd) chk(o_apd_en, r.res[0]);
      chk(o_wp_status, r.wp_exp);
      stat();
      chk(o_intrq, 1'b0);
    end
    f8 = 1'b0;
    // Timer of two steps fires; a zero count keeps it quiet
    tf(3'h2, 8'h02);
    issue(8'h97);
    repeat (3) @(negedge clk);
    chk(o_apd_req, 1'b0);
    for (n = 0; n < 20 && o_apd_req !== 1'b1; n++) @(negedge clk);
    chk(o_apd_req, 1'b1);
    tf(3'h2, 8'h00);
    issue(8'he3);
    repeat (20) @(negedge clk);
    chk({o_apd_en, o_apd_req}, 2'h0);
    // Two sectors; a command written while busy is ignored
    start(1'b0);
    tf(3'h6, 8'he4);
    wr4(8'h02, 8'h10, 8'h20, 8'h30);
    issue(8'hc8);
    chk(o_lba, 48'h0000_0430_2010);
    tf(3'h7, 8'h95);
    run(2, 9);
    chk(o_lba, 48'h0000_0430_2011);
    chk({words, hsum}, {32'h0000_0200, esum});
    chk({o_err, o_drq}, 2'h0);
    issue(8'he4);
    chk({o_drq, o_intrq, o_dd}, {2'h3, 16'h0100});
    for (n = 0; n < 255; n++) pio();
    chk(o_dd, 16'h01ff);
    pio();
    chk(o_drq, 1'b0);
    // Count 0 with a slow host, fault in the third sector
    start(1'b1);
    wr4(8'h00, 8'hf0, 8'h20, 8'h30);
    issue(8'hc8);
    run(3, 2);
    chk(o_lba, 48'h0000_0430_20f2);
    chk({o_err, o_abrt}, 2'h2);
    chk({words, hsum}, {32'h0000_0200, esum});
    // Extended read, count 0, fault in the second sector
    start(1'b0);
    tf(3'h6, 8'h40);
    wr4(8'h00, 8'h44, 8'h55, 8'h66);
    wr4(8'h00, 8'h11, 8'h22, 8'h33);
    issue(8'h25);
    chk(o_lba, 48'h6655_4433_2211);
    run(2, 1);
    chk(o_lba, 48'h6655_4433_2212);
    chk({words, hsum}, {32'h0000_0100, esum});
    // Reset in mid-fill drops the read; a later command still runs
    issue(8'hc8);
    chk({o_bsy, o_fetch}, 2'h3);
    resetn = 1'b0;
    repeat (2) @(negedge clk);
    chk({o_bsy, o_fetch, o_err, o_intrq}, 4'h0);
    chk(o_lba, 48'h0000_0000_0000);
    resetn = 1'b1;
    issue(8'he1);
    chk({o_bsy, o_intrq, o_idle}, 3'h3);
    give_verdict();
  end
endmodule
`default_nettype wire
